/* File: design/flc_loop_ctrl.v */
// Summary of operation
// [RULE1] Software derives numerator and denominator from frequencies divided by their GCD.
// [RULE2] Software computes divisor, numerator and denominator with frequencies in hertz.
// [RULE3] Software programs a numerator and denominator that are coprime.
// [RULE4] Software keeps the numerator strictly below the denominator.
// [RULE5] Enabled with hold set: feedback stops, output frequency stays unchanged.
// [RULE6] Enabled with stopped reference: loop runs freely regardless of hold.
// [RULE7] Hold clear: loop relocks whenever the reference returns.
// [RULE8] Software sets hold before changing other fields on a running loop.
// [RULE9] Writing one to bit 2 applies pending fields; meaningful only while enabled.
// [RULE10] Hold bit 1 resets to one; holds feedback and keeps the integrator.
// [RULE11] Enable bit 0 resets to zero; software sets it last.
// [RULE12] Lock threshold in bits 31:28 defaults to 0x8, range 0x0 to 0xF.
// [RULE13] Lock-detect enable bit 27 defaults to one.
// [RULE14] Phase-detect enable bit 22 defaults to zero.
// [RULE15] Reference-detect enable bit 21 defaults to one.
// [RULE16] Pre-divider bits 17:16 divide by 1, 2, 4, 8; default 00.
// [RULE17] Source bits 15:12 pick master, none, PDM, port 1 or port 2 clock.
// [RULE18] Integer multiplier in bits 9:0 defaults to 0x004.
// [RULE19] Denominator in bits 31:16, numerator in bits 15:0, both default zero.
// [RULE20] The free-running loop output may be chosen as system clock source.
// [RULE21] While enabled, written fields wait for the apply strobe, changing together.
// [RULE22] While disabled, written fields take effect directly.
// [RULE23] A reserved source code behaves as no reference, a stopped reference.
`timescale 1ns/1ps
`default_nettype none

module flc_loop_ctrl (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rstn,
  // Host control port.
  input  wire        hostWrEn,
  input  wire        hostRdEn,
  input  wire [15:0] hostAddr,
  input  wire [31:0] hostWrData,
  output reg  [31:0] hostRdData,
  // Reference pins.
  input  wire        masterClockInput,
  input  wire        pdmClockInput,
  input  wire        serialPort1BitClock,
  input  wire        serialPort2BitClock,
  // System clock source choice and status to the clock tree.
  input  wire        sysClkFromLoopReq,
  output reg         systemClockFromLoop,
  // Active configuration driven to the analogue loop.
  output reg         loopEnable,
  output reg         feedbackRun,
  output reg         freeRunning,
  output reg         refPresent,
  output reg  [3:0]  lockThreshold,
  output reg         lockDetectEnable,
  output reg         phaseDetectEnable,
  output reg         referenceDetectEnable,
  output reg  [1:0]  referencePredivider,
  output reg  [3:0]  referenceSourceSelect,
  output reg  [9:0]  integerMultiplier,
  output reg  [15:0] fractionDenominator,
  output reg  [15:0] fractionNumerator,
  output reg         configApplied
);

`include "flc_consts.vh"

  // Loop state codes.
  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_LOCK = 3'b010;
  localparam [2:0] ST_FREE = 3'b100;

  reg        loopEnable_ff;
  reg        loopHold_ff;
  reg [31:0] pendRef_ff;
  reg [31:0] pendFrac_ff;
  reg [7:0]  refIdle_ff;
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg        wrStrobe;
  wire       refTick;
  wire       wrMain;
  wire       wrRef;
  wire       wrFrac;
  wire       applyNow;
  wire       refAlive;

  assign wrMain = hostWrEn && (hostAddr == `FLC_ADDR_MAIN);
  assign wrRef  = hostWrEn && (hostAddr == `FLC_ADDR_REF);
  assign wrFrac = hostWrEn && (hostAddr == `FLC_ADDR_FRAC);

  // The apply strobe only acts while the loop is enabled.
  always @* begin
    wrStrobe = wrMain && hostWrData[`FLC_BIT_UPD] && loopEnable_ff; // [RULE9]
  end

  // Selected and divided reference from the pins.
  flc_ref_mux uRefMux (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .srcSel              (referenceSourceSelect),
    .preDiv              (referencePredivider),
    .masterClockInput    (masterClockInput),
    .pdmClockInput       (pdmClockInput),
    .serialPort1BitClock (serialPort1BitClock),
    .serialPort2BitClock (serialPort2BitClock),
    .refTick             (refTick)
  );

  // Main control bits; the apply bit is a strobe and is not stored.
  always @(posedge core_clk) begin
    if (!rstn) begin
      loopEnable_ff <= `FLC_RST_EN;   // [RULE11]
      loopHold_ff   <= `FLC_RST_HOLD; // [RULE10]
    end else if (wrMain) begin
      loopEnable_ff <= hostWrData[`FLC_BIT_EN];
      loopHold_ff   <= hostWrData[`FLC_BIT_HOLD];
    end
  end

  // Pending copies of the configuration as software wrote them.
  always @(posedge core_clk) begin
    if (!rstn) begin
      pendRef_ff <= 32'h0;
      pendRef_ff[`FLC_THR_HI:`FLC_THR_LO] <= `FLC_RST_THR;
      pendRef_ff[`FLC_BIT_LOCKDET]        <= `FLC_RST_LOCKDET;
      pendRef_ff[`FLC_BIT_PHASEDET]       <= `FLC_RST_PHASEDET;
      pendRef_ff[`FLC_BIT_REFDET]         <= `FLC_RST_REFDET;
      pendRef_ff[`FLC_DIV_HI:`FLC_DIV_LO] <= `FLC_RST_DIV;
      pendRef_ff[`FLC_SRC_HI:`FLC_SRC_LO] <= `FLC_RST_SRC;
      pendRef_ff[`FLC_MUL_HI:`FLC_MUL_LO] <= `FLC_RST_MUL;
      pendFrac_ff <= {`FLC_RST_DEN, `FLC_RST_NUM};
    end else begin
      if (wrRef) begin
        pendRef_ff <= hostWrData;
      end
      if (wrFrac) begin
        pendFrac_ff <= hostWrData;
      end
    end
  end

  // Active fields follow the pending ones directly when disabled, else on the strobe.
  assign applyNow = wrStrobe || !loopEnable_ff; // [RULE21] [RULE22]

  always @(posedge core_clk) begin
    if (!rstn) begin
      lockThreshold         <= `FLC_RST_THR;       // [RULE12]
      lockDetectEnable      <= `FLC_RST_LOCKDET;   // [RULE13]
      phaseDetectEnable     <= `FLC_RST_PHASEDET;  // [RULE14]
      referenceDetectEnable <= `FLC_RST_REFDET;    // [RULE15]
      referencePredivider   <= `FLC_RST_DIV;       // [RULE16]
      referenceSourceSelect <= `FLC_RST_SRC;       // [RULE17]
      integerMultiplier     <= `FLC_RST_MUL;       // [RULE18]
      fractionDenominator   <= `FLC_RST_DEN;       // [RULE19]
      fractionNumerator     <= `FLC_RST_NUM;
      configApplied         <= 1'b0;
    end else begin
      configApplied <= wrStrobe;
      if (applyNow) begin
        lockThreshold         <= pendRef_ff[`FLC_THR_HI:`FLC_THR_LO];
        lockDetectEnable      <= pendRef_ff[`FLC_BIT_LOCKDET];
        phaseDetectEnable     <= pendRef_ff[`FLC_BIT_PHASEDET];
        referenceDetectEnable <= pendRef_ff[`FLC_BIT_REFDET];
        referencePredivider   <= pendRef_ff[`FLC_DIV_HI:`FLC_DIV_LO];
        referenceSourceSelect <= pendRef_ff[`FLC_SRC_HI:`FLC_SRC_LO];
        integerMultiplier     <= pendRef_ff[`FLC_MUL_HI:`FLC_MUL_LO];
        fractionDenominator   <= pendFrac_ff[`FLC_DEN_HI:`FLC_DEN_LO];
        fractionNumerator     <= pendFrac_ff[`FLC_NUM_HI:`FLC_NUM_LO];
      end
    end
  end

  // Reference watchdog: a run of cycles without a divided edge means stopped.
  always @(posedge core_clk) begin
    if (!rstn) begin
      refIdle_ff <= `FLC_REF_TIMEOUT;
    end else if (refTick) begin
      refIdle_ff <= 8'h00;
    end else if (refIdle_ff != `FLC_REF_TIMEOUT) begin
      refIdle_ff <= refIdle_ff + 8'h01;
    end
  end

  assign refAlive = (refIdle_ff != `FLC_REF_TIMEOUT);

  // Loop state: off, locking to the reference, or free running.
  always @* begin
    case (state_ff)
      ST_OFF: begin
        if (loopEnable_ff && !loopHold_ff && refAlive) begin
          nxt_state = ST_LOCK;
        end else if (loopEnable_ff) begin
          nxt_state = ST_FREE;
        end else begin
          nxt_state = ST_OFF;
        end
      end
      ST_LOCK: begin
        if (!loopEnable_ff) begin
          nxt_state = ST_OFF;
        end else if (loopHold_ff || !refAlive) begin
          nxt_state = ST_FREE; // [RULE5] [RULE6]
        end else begin
          nxt_state = ST_LOCK;
        end
      end
      ST_FREE: begin
        if (!loopEnable_ff) begin
          nxt_state = ST_OFF;
        end else if (!loopHold_ff && refAlive) begin
          nxt_state = ST_LOCK; // [RULE7]
        end else begin
          nxt_state = ST_FREE;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Status and loop drive outputs, registered.
  always @(posedge core_clk) begin
    if (!rstn) begin
      loopEnable          <= 1'b0;
      feedbackRun         <= 1'b0;
      freeRunning         <= 1'b0;
      refPresent          <= 1'b0;
      systemClockFromLoop <= 1'b0;
    end else begin
      loopEnable          <= loopEnable_ff;
      feedbackRun         <= (nxt_state == ST_LOCK);   // [RULE10]
      freeRunning         <= (nxt_state == ST_FREE);   // [RULE6]
      refPresent          <= refAlive;
      systemClockFromLoop <= sysClkFromLoopReq && loopEnable_ff; // [RULE20]
    end
  end

  // Read back: pending configuration and live state.
  always @(posedge core_clk) begin
    if (!rstn) begin
      hostRdData <= 32'h0;
    end else if (hostRdEn) begin
      case (hostAddr)
        `FLC_ADDR_MAIN: hostRdData <= {27'h0, refAlive, (state_ff == ST_FREE), 1'b0, loopHold_ff, loopEnable_ff};
        `FLC_ADDR_REF:  hostRdData <= pendRef_ff;
        `FLC_ADDR_FRAC: hostRdData <= pendFrac_ff;
        default:        hostRdData <= 32'h0;
      endcase
    end
  end

endmodule // flc_loop_ctrl

`default_nettype wire

/* File: design/flc_consts.vh */
`ifndef FLC_CONSTS_VH
`define FLC_CONSTS_VH

// Register addresses on the host control port.
`define FLC_ADDR_MAIN        16'h1c00
`define FLC_ADDR_REF         16'h1c04
`define FLC_ADDR_FRAC        16'h1c08

// Main control register fields.
`define FLC_BIT_EN           0
`define FLC_BIT_HOLD         1
`define FLC_BIT_UPD          2
`define FLC_RST_EN           1'h0
`define FLC_RST_HOLD         1'h1

// Reference control register fields.
`define FLC_THR_HI           31
`define FLC_THR_LO           28
`define FLC_BIT_LOCKDET      27
`define FLC_BIT_PHASEDET     22
`define FLC_BIT_REFDET       21
`define FLC_DIV_HI           17
`define FLC_DIV_LO           16
`define FLC_SRC_HI           15
`define FLC_SRC_LO           12
`define FLC_MUL_HI           9
`define FLC_MUL_LO           0
`define FLC_RST_THR          4'h8
`define FLC_RST_LOCKDET      1'h1
`define FLC_RST_PHASEDET     1'h0
`define FLC_RST_REFDET       1'h1
`define FLC_RST_DIV          2'h0
`define FLC_RST_SRC          4'h3
`define FLC_RST_MUL          10'h004

// Fraction register fields.
`define FLC_DEN_HI           31
`define FLC_DEN_LO           16
`define FLC_NUM_HI           15
`define FLC_NUM_LO           0
`define FLC_RST_DEN          16'h0000
`define FLC_RST_NUM          16'h0000

// Reference source codes.
`define FLC_SRC_MCLK         4'h0
`define FLC_SRC_NONE         4'h3
`define FLC_SRC_PDM          4'h5
`define FLC_SRC_SP1          4'h8
`define FLC_SRC_SP2          4'h9

// Reference is deemed stopped after this many core cycles with no edge.
`define FLC_REF_TIMEOUT      8'hff

`endif

/* File: design/flc_ref_mux.v */
`timescale 1ns/1ps
`default_nettype none

module flc_ref_mux (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rstn,
  // Source selection and prescaler.
  input  wire [3:0]  srcSel,
  input  wire [1:0]  preDiv,
  // Candidate reference pins.
  input  wire        masterClockInput,
  input  wire        pdmClockInput,
  input  wire        serialPort1BitClock,
  input  wire        serialPort2BitClock,
  // Divided reference edge, one cycle pulse.
  output reg         refTick
);

`include "flc_consts.vh"

  reg  [3:0] syncA_ff;
  reg  [3:0] syncB_ff;
  reg  [3:0] prev_ff;
  reg  [2:0] divCnt_ff;
  reg        selLvl;
  reg        selPrev;
  reg  [2:0] divMask;
  wire       rise;

  // Two stages of synchronisation per pin, then one for edge detection.
  always @(posedge core_clk) begin
    if (!rstn) begin
      syncA_ff <= 4'h0;
      syncB_ff <= 4'h0;
      prev_ff  <= 4'h0;
    end else begin
      syncA_ff <= {serialPort2BitClock, serialPort1BitClock, pdmClockInput, masterClockInput};
      syncB_ff <= syncA_ff;
      prev_ff  <= syncB_ff;
    end
  end

  // Source selection; reserved codes and the no-input code see a stopped reference.
  always @* begin
    selLvl  = 1'b0;
    selPrev = 1'b0;
    case (srcSel)
      `FLC_SRC_MCLK: begin selLvl = syncB_ff[0]; selPrev = prev_ff[0]; end // [RULE17]
      `FLC_SRC_PDM:  begin selLvl = syncB_ff[1]; selPrev = prev_ff[1]; end
      `FLC_SRC_SP1:  begin selLvl = syncB_ff[2]; selPrev = prev_ff[2]; end
      `FLC_SRC_SP2:  begin selLvl = syncB_ff[3]; selPrev = prev_ff[3]; end
      default:       begin selLvl = 1'b0; selPrev = 1'b0; end // [RULE23]
    endcase
  end

  assign rise = selLvl & ~selPrev;

  // Prescaler mask for divide by 1, 2, 4 or 8.
  always @* begin
    case (preDiv)
      2'h0:    divMask = 3'h0; // [RULE16]
      2'h1:    divMask = 3'h1;
      2'h2:    divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  end

  // Count rising edges and pass one of every N on.
  always @(posedge core_clk) begin
    if (!rstn) begin
      divCnt_ff <= 3'h0;
      refTick   <= 1'b0;
    end else begin
      refTick <= 1'b0;
      if (rise) begin
        if ((divCnt_ff & divMask) == divMask) begin
          divCnt_ff <= 3'h0;
          refTick   <= 1'b1;
        end else begin
          divCnt_ff <= divCnt_ff + 3'h1;
        end
      end
    end
  end

endmodule // flc_ref_mux

`default_nettype wire

/* File: test/flc_loop_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module flc_loop_ctrl_monitor (
  // Clock, reset and host writes.
  input wire logic        core_clk, rstn, hostWrEn, sysClkFromLoopReq,
  input wire logic [15:0] hostAddr,
  input wire logic [31:0] hostWrData,
  // Loop status.
  input wire logic        systemClockFromLoop, loopEnable, feedbackRun, freeRunning, refPresent, configApplied,
  // Active configuration.
  input wire logic        lockDetectEnable, phaseDetectEnable, referenceDetectEnable,
  input wire logic [3:0]  lockThreshold, referenceSourceSelect,
  input wire logic [1:0]  referencePredivider,
  input wire logic [9:0]  integerMultiplier,
  input wire logic [15:0] fractionDenominator, fractionNumerator
);
  // All checks run on the core clock and rest during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // An apply strobe lasts a single cycle.
  sequence s_pulseEnds;
    configApplied ##1 !configApplied;
  endsequence

  property p_resetDefaults;
    $past(rstn) == 1'b0 |-> lockThreshold == 4'h8 && lockDetectEnable && !phaseDetectEnable && referenceDetectEnable
      && referencePredivider == 2'h0 && referenceSourceSelect == 4'h3 && integerMultiplier == 10'h004
      && fractionDenominator == 16'h0 && fractionNumerator == 16'h0 && !loopEnable;
  endproperty
  property p_runExclusive;
    feedbackRun |-> !freeRunning;
  endproperty
  property p_refLost;
    !refPresent |-> !feedbackRun;
  endproperty
  property p_offIdle;
    !loopEnable && $past(loopEnable) == 1'b0 |-> !feedbackRun && !freeRunning && !systemClockFromLoop;
  endproperty
  property p_applyCause;
    configApplied |-> $past(hostWrEn && hostAddr == 16'h1c00 && hostWrData[2]);
  endproperty
  property p_applyPulse;
    configApplied |-> s_pulseEnds;
  endproperty
  property p_frozen;
    loopEnable && $past(loopEnable) && !configApplied |-> $stable(integerMultiplier)
      && $stable(fractionNumerator) && $stable(referenceSourceSelect);
  endproperty
  property p_system_clock;
    systemClockFromLoop |-> $past(sysClkFromLoopReq);
  endproperty

  a_resetDefaults: assert property (p_resetDefaults) else $error("config outputs wrong after reset");
  a_runExclusive: assert property (p_runExclusive) else $error("locking and free running together");
  a_refLost: assert property (p_refLost) else $error("feedback runs without a reference");
  a_offIdle: assert property (p_offIdle) else $error("disabled loop shows activity");
  a_applyCause: assert property (p_applyCause) else $error("apply pulse without apply write");
  a_applyPulse: assert property (p_applyPulse) else $error("apply pulse too long");
  a_frozen: assert property (p_frozen) else $error("active field moved without apply");
  a_system_clock: assert property (p_system_clock) else $error("system clock choice without request");
endmodule // flc_loop_ctrl_monitor

bind flc_loop_ctrl flc_loop_ctrl_monitor i_flc_loop_ctrl_monitor (.core_clk, .rstn, .hostWrEn, .sysClkFromLoopReq,
  .hostAddr, .hostWrData, .systemClockFromLoop, .loopEnable, .feedbackRun, .freeRunning, .refPresent,
  .configApplied, .lockDetectEnable, .phaseDetectEnable, .referenceDetectEnable, .lockThreshold,
  .referenceSourceSelect, .referencePredivider, .integerMultiplier, .fractionDenominator, .fractionNumerator);

`default_nettype wire

/* File: test/flc_loop_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module flc_loop_ctrl_tb_top;
  logic        core_clk, rstn, hostWrEn, hostRdEn, refClk, refOn, sysReq, rdSeen;
  logic [15:0] hostAddr;
  logic [31:0] hostWrData, hostRdData, r;
  logic [15:0] den;
  logic [1:0]  dv, pv;
  logic        sysOut, en, fb, fr, rp, thrLd, ph, rd_, ap;
  logic [3:0]  thr, src;
  logic [1:0]  div;
  logic [9:0]  mul;
  logic [15:0] dOut, nOut;
  logic [31:0] expQ[$];
  int          fails, nTests;
  logic [3:0]  codes[6] = '{4'h3, 4'h6, 4'h0, 4'h5, 4'h8, 4'h9};

  flc_loop_ctrl i_flc_loop_ctrl (.core_clk(core_clk), .rstn(rstn), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData), .masterClockInput(refClk),
    .pdmClockInput(refClk), .serialPort1BitClock(refClk), .serialPort2BitClock(refClk),
    .sysClkFromLoopReq(sysReq), .systemClockFromLoop(sysOut), .loopEnable(en), .feedbackRun(fb),
    .freeRunning(fr), .refPresent(rp), .lockThreshold(thr), .lockDetectEnable(thrLd), .phaseDetectEnable(ph),
    .referenceDetectEnable(rd_), .referencePredivider(div), .referenceSourceSelect(src),
    .integerMultiplier(mul), .fractionDenominator(dOut), .fractionNumerator(nOut), .configApplied(ap));

  // Core clock at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("tests=%0d fails=%0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hostWrEn <= 1'b1; hostAddr <= a; hostWrData <= d;
    @(posedge core_clk);
    hostWrEn <= 1'b0;
  endtask

  // A read notes its expected word; the watcher below compares it.
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk);
    hostRdEn <= 1'b1; hostAddr <= a; expQ.push_back(e);
    @(posedge core_clk);
    hostRdEn <= 1'b0;
  endtask

  // Read data is taken one cycle after the read edge.
  always @(posedge core_clk) begin
    rdSeen <= hostRdEn;
    if (rdSeen && expQ.size() > 0) chk(hostRdData, expQ.pop_front());
  end

  // Reference pins toggle only while switched on, otherwise stand still.
  always @(posedge core_clk) begin
    if (refOn) refClk <= ~refClk;
    sysReq <= $urandom;
  end

  // Hang guard sized well above the expected run.
  initial begin
    #(40 * 20000);
    fails++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0; hostWrEn = 1'b0; hostRdEn = 1'b0; hostAddr = 16'h0; hostWrData = 32'h0;
    refClk = 1'b0; refOn = 1'b0; sysReq = 1'b0; rdSeen = 1'b0;
    void'($urandom(32'hcf590c5d));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd(16'h1c00, 32'h2);
    rd(16'h1c04, 32'h88203004);
    rd(16'h1c08, 32'h0);
    rd(16'h1c0c, 32'h0);
    // Disabled loop: writes land on the active outputs directly.
    r = $urandom & 32'hf863f3ff;
    wr(16'h1c04, r);
    rd(16'h1c04, r);
    chk(mul, r[9:0]);
    chk(thr, r[31:28]);
    chk(ph, r[22]);
    chk(thrLd, r[27]);
    chk(rd_, r[21]);
    // The ratio is a coprime pair as software would derive it in hertz.
    den = $urandom | 16'h2;
    wr(16'h1c08, {den, den - 16'h1});
    rd(16'h1c08, {den, den - 16'h1});
    chk(dOut, den);
    chk(nOut, den - 16'h1);
    // Running loop: hold, rewrite, apply, release, for each of the five named source codes and reserved code 6.
    refOn <= 1'b1;
    pv = r[17:16];
    foreach (codes[i]) begin
      dv = $urandom;
      wr(16'h1c00, 32'h3);
      wr(16'h1c04, 32'h88200004 | (32'(dv) << 16) | (32'(codes[i]) << 12));
      repeat (3) @(posedge core_clk);
      chk(div, pv);
      wr(16'h1c00, 32'h7);
      wr(16'h1c00, 32'h1);
      repeat (300) @(posedge core_clk);
      chk(src, codes[i]);
      chk(div, dv);
      pv = dv;
      chk(rp, i > 1);
      chk(fb, i > 1);
      chk(fr, i < 2);
    end
    // Hold on a locked loop stops the feedback.
    wr(16'h1c00, 32'h3);
    repeat (3) @(posedge core_clk);
    chk(fb, 1'b0);
    chk(fr, 1'b1);
    wr(16'h1c00, 32'h2);
    repeat (3) @(posedge core_clk);
    chk(en, 1'b0);
    repeat (4) @(posedge core_clk);
    tally_and_finish();
  end
endmodule // flc_loop_ctrl_tb_top

`default_nettype wire
